/* File: verilog/i2csm_defs.svh */
// register offsets, field positions, reset values and constants of the control block
// Functional notes
// [RQ1] soft reset bit holds controller in reset
// [RQ2] alert request bit drives the alert pin
// [RQ3] checksum transfer cleared on done, start/stop, disable
// [RQ4] ack position picks current or next byte
// [RQ5] acknowledge enable decides ack for received bytes
// [RQ6] stop request: set on timeout, cleared on stop
// [RQ7] start request cleared on start or disable
// [RQ8] disable clears ack position and ack enable
// [RQ9] slave stretches clock unless stretch disabled
// [RQ10] general call address answered only when enabled
// [RQ11] checksum enable switches the crc calculator
// [RQ12] address resolution support enabled in smbus mode
// [RQ13] role select: smbus device or host
// [RQ14] protocol select: plain i2c or smbus
// [RQ15] peripheral enable switches controller on
// [RQ16] overrun/underrun flagged when stretching disabled
// [RQ17] separate flags for bus, arbitration, ack, checksum
// [RQ18] smbus timeout and alert flags in smbus mode
// [RQ19] frame flags: rx fall, tx rise
// [RQ20] frame flag: tx fall
// [RQ21] control register: 16/32-bit access, zero reset
// [RQ22] crc-8 polynomial x8+x2+x+1 over all bytes
// [RQ23] reserved bits read zero, writes ignored
`ifndef I2CSM_DEFS_SVH
`define I2CSM_DEFS_SVH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define I2CSM_OFF_CTL     8'h00
`define I2CSM_OFF_FLAGS   8'h40
`define I2CSM_OFF_FRAME   8'h44
`define I2CSM_OFF_PEC     8'h48

// ---------------------------------------------------------------
// control register fields
// ---------------------------------------------------------------
`define I2CSM_B_SRST      15
`define I2CSM_B_ALERT     13
`define I2CSM_B_PECTX     12
`define I2CSM_B_ACKPOS    11
`define I2CSM_B_ACKNOWLEDGE_ENABLE     10
`define I2CSM_B_STOP      9
`define I2CSM_B_START     8
`define I2CSM_B_NOSTR     7
`define I2CSM_B_GENERAL_CALL_ENABLE      6
`define I2CSM_B_CHECKSUM_CALC_ENABLE     5
`define I2CSM_B_ADDRESS_RESOLUTION_ENABLE     4
`define I2CSM_B_ROLE      3
`define I2CSM_B_SMB       1
`define I2CSM_B_EN        0
`define I2CSM_CTL_MASK    16'hbffb
`define I2CSM_CTL_RESET   16'h0000

// ---------------------------------------------------------------
// flag register fields
// ---------------------------------------------------------------
`define I2CSM_F_BUS       0
`define I2CSM_F_ARB       1
`define I2CSM_F_NOACK     2
`define I2CSM_F_OVR       3
`define I2CSM_F_PEC       4
`define I2CSM_F_TMO       5
`define I2CSM_F_ALERT     6
`define I2CSM_F_RXFF      7
`define I2CSM_F_TXFR      8
`define I2CSM_F_TXFF      9
`define I2CSM_FLAGS_RESET 10'h000

// ---------------------------------------------------------------
// crc and addressing
// ---------------------------------------------------------------
`define I2CSM_CRC_POLY    8'h07
`define I2CSM_CRC_INIT    8'h00
`define I2CSM_GC_ADDR     7'h00

`endif

/* File: verilog/i2csm_pkg.sv */
// types shared by the control block modules
package i2csm_pkg;

  typedef struct packed {
    logic [15:0] ctl;
    logic        frame_en;
    logic [9:0]  flags;
    logic [31:0] rdata;
    logic        ready;
    logic        slverr;
    logic        run;
    logic        ack_next;
    logic        pec_next;
    logic        rx_ack;
    logic        rx_pec;
    logic        scl_oe;
    logic        alert_oe;
    logic        tx_frame;
    logic        rxf_q;
    logic        alert_q;
    logic        gc_respond;
  } i2csm_state_t;

  typedef struct packed {
    logic [7:0] crc;
  } i2csm_crc_t;

endpackage

/* File: verilog/i2csm_sync.sv */
// two-flop synchroniser for pin inputs
`timescale 1ns/100ps
module i2csm_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic             clk_en,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  import i2csm_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } i2csm_sync_t;

  i2csm_sync_t st;
  i2csm_sync_t next_st;

  always_comb begin
    next_st = st;
    if (clk_en) begin
      next_st.meta = d;
      next_st.sync = st.meta;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign q = st.sync;
endmodule

/* File: verilog/i2csm_crc8.sv */
// byte-wide crc-8 calculator for packet error checking
`timescale 1ns/100ps
`include "i2csm_defs.svh"
module i2csm_crc8 (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       clk_en,
  input  wire logic       clr,
  input  wire logic       byte_valid,
  input  wire logic [7:0] byte_in,
  output logic      [7:0] crc
);
  import i2csm_pkg::*;

  i2csm_crc_t st;
  i2csm_crc_t next_st;
  logic [7:0] c;

  always_comb begin
    next_st = st;
    c = st.crc ^ byte_in;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ `I2CSM_CRC_POLY) : (c << 1); // [RQ22]
    end
    if (clk_en) begin
      if (clr) begin
        next_st.crc = `I2CSM_CRC_INIT;
      end else if (byte_valid) begin
        next_st.crc = c;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign crc = st.crc;
endmodule

/* File: verilog/i2csm_ctrl.sv */
// control register, error and frame flags of the two-wire serial controller
//
// Implementation choice: register access over APB.
`timescale 1ns/100ps
`include "i2csm_defs.svh"
module i2csm_ctrl (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  // apb slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic      [31:0] prdata,
  output logic             pslverr,
  // events from the byte engine
  input  wire logic        evt_start,
  input  wire logic        evt_stop,
  input  wire logic        evt_pec_done,
  input  wire logic        evt_timeout,
  input  wire logic        evt_bus_err,
  input  wire logic        evt_arb_lost,
  input  wire logic        evt_no_ack,
  input  wire logic        evt_data_late,
  input  wire logic        byte_done,
  input  wire logic [7:0]  byte_data,
  input  wire logic        pec_check,
  input  wire logic        addr_valid,
  input  wire logic        slave_active,
  input  wire logic        data_wait,
  input  wire logic        master_busy,
  input  wire logic        alert_served,
  // pins
  input  wire logic        alert_pin_i,
  input  wire logic        rx_frame_i,
  output logic             alert_pin_o,
  output logic             alert_pin_oe,
  output logic             scl_o,
  output logic             scl_oe,
  output logic             tx_frame,
  // controls to the byte engine
  output logic             core_enable,
  output logic             start_req,
  output logic             stop_req,
  output logic             rx_ack,
  output logic             rx_pec_byte,
  output logic             pec_enable,
  output logic             smbus_mode,
  output logic             smbus_host,
  output logic             arp_support,
  output logic             gc_respond,
  output logic      [7:0]  pec_value
);
  import i2csm_pkg::*;

  i2csm_state_t st;
  i2csm_state_t next_st;
  logic [1:0]   pins_s;
  logic [7:0]   crc;
  logic         crc_clr;
  logic         acc;
  logic         wr;
  logic         hit_ctl;
  logic         hit_flags;
  logic         hit_frame;
  logic         hit_pec;
  logic [15:0]  ctl_w;
  logic [15:0]  lane_m;
  logic [9:0]   set_f;
  logic [9:0]   clr_f;
  logic         soft_reset_bit;
  logic         smb;

  // ---------------------------------------------------------------
  // pin synchronisers and crc
  // ---------------------------------------------------------------
  i2csm_sync #(
    .WIDTH (2)
  ) u_sync (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .clk_en  (clk_en),
    .d       ({rx_frame_i, alert_pin_i}),
    .q       (pins_s)
  );

  assign soft_reset_bit  = st.ctl[`I2CSM_B_SRST];
  assign smb     = st.ctl[`I2CSM_B_SMB];
  // crc restarts per message and is off unless enabled
  assign crc_clr = !st.run || !st.ctl[`I2CSM_B_CHECKSUM_CALC_ENABLE] || evt_start || evt_stop; // [RQ11]

  i2csm_crc8 u_crc (
    .sys_clk    (sys_clk),
    .rst_n      (rst_n),
    .clk_en     (clk_en),
    .clr        (crc_clr),
    .byte_valid (byte_done),
    .byte_in    (byte_data),
    .crc        (crc)
  );

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  assign acc       = psel && penable && st.ready;
  assign wr        = acc && pwrite;
  assign hit_ctl   = (paddr == `I2CSM_OFF_CTL);
  assign hit_flags = (paddr == `I2CSM_OFF_FLAGS);
  assign hit_frame = (paddr == `I2CSM_OFF_FRAME);
  assign hit_pec   = (paddr == `I2CSM_OFF_PEC);
  // half-word lanes only; upper lanes hold nothing
  assign lane_m    = {{8{pstrb[1]}}, {8{pstrb[0]}}}; // [RQ21]

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_st = st;
    ctl_w   = st.ctl;
    set_f   = '0;
    clr_f   = '0;
    if (clk_en) begin
      // apb answer one cycle into the access phase
      next_st.ready  = psel && penable && !st.ready;
      next_st.slverr = psel && penable && !st.ready &&
                       !(hit_ctl || hit_flags || hit_frame || hit_pec);
      next_st.rdata  = '0;
      if (psel && penable && !st.ready) begin
        unique case (1'b1)
          hit_ctl: begin
            next_st.rdata = {16'h0000, st.ctl & `I2CSM_CTL_MASK}; // [RQ23]
          end
          hit_flags: begin
            next_st.rdata = {22'h000000, st.flags};
          end
          hit_frame: begin
            next_st.rdata = {31'h00000000, st.frame_en};
          end
          hit_pec: begin
            next_st.rdata = {24'h000000, crc};
          end
          default: begin
            next_st.rdata = '0;
          end
        endcase
      end

      // hardware clears of control bits
      if (evt_pec_done || evt_start || evt_stop) begin
        ctl_w[`I2CSM_B_PECTX] = 1'b0; // [RQ3]
      end
      if (evt_stop) begin
        ctl_w[`I2CSM_B_STOP] = 1'b0; // [RQ6]
      end
      if (evt_start) begin
        ctl_w[`I2CSM_B_START] = 1'b0; // [RQ7]
      end
      if (alert_served) begin
        ctl_w[`I2CSM_B_ALERT] = 1'b0; // [RQ2]
      end
      // software write over the lanes it strobes
      if (wr && hit_ctl) begin
        ctl_w = ((ctl_w & ~lane_m) | (pwdata[15:0] & lane_m)) & `I2CSM_CTL_MASK; // [RQ21] [RQ23]
      end
      if (!ctl_w[`I2CSM_B_EN]) begin
        ctl_w[`I2CSM_B_ACKPOS] = 1'b0; // [RQ8]
        ctl_w[`I2CSM_B_ACKNOWLEDGE_ENABLE]  = 1'b0; // [RQ8]
        ctl_w[`I2CSM_B_START]  = 1'b0; // [RQ7]
        ctl_w[`I2CSM_B_PECTX]  = 1'b0; // [RQ3]
      end
      // timeout sets stop; a set beats a same-cycle clear
      if (st.run && smb && evt_timeout) begin
        ctl_w[`I2CSM_B_STOP] = 1'b1; // [RQ6]
      end
      next_st.ctl = ctl_w;
      if (wr && hit_frame && pstrb[0]) begin
        next_st.frame_en = pwdata[0];
      end

      // controller runs only while enabled and out of soft reset
      next_st.run = ctl_w[`I2CSM_B_EN] && !ctl_w[`I2CSM_B_SRST]; // [RQ1] [RQ15]

      // ack and checksum position for the received byte
      if (byte_done) begin
        next_st.ack_next = st.ctl[`I2CSM_B_ACKNOWLEDGE_ENABLE];
        next_st.pec_next = st.ctl[`I2CSM_B_PECTX];
      end
      if (st.ctl[`I2CSM_B_ACKPOS]) begin
        next_st.rx_ack = next_st.ack_next; // [RQ4]
        next_st.rx_pec = next_st.pec_next; // [RQ4]
      end else begin
        next_st.rx_ack = ctl_w[`I2CSM_B_ACKNOWLEDGE_ENABLE]; // [RQ4] [RQ5]
        next_st.rx_pec = ctl_w[`I2CSM_B_PECTX]; // [RQ4]
      end

      // slave clock hold while data is not ready
      next_st.scl_oe = st.run && slave_active && data_wait &&
                       !st.ctl[`I2CSM_B_NOSTR]; // [RQ9]
      next_st.alert_oe = ctl_w[`I2CSM_B_ALERT] && !ctl_w[`I2CSM_B_SRST]; // [RQ2]
      next_st.gc_respond = st.run && st.ctl[`I2CSM_B_GENERAL_CALL_ENABLE] && addr_valid &&
                           (byte_data[7:1] == `I2CSM_GC_ADDR); // [RQ10]
      next_st.tx_frame = st.run && master_busy;

      // edge history of synchronised pins
      next_st.rxf_q   = pins_s[1];
      next_st.alert_q = pins_s[0];

      // error and frame events
      if (st.run) begin
        set_f[`I2CSM_F_BUS]   = evt_bus_err; // [RQ17]
        set_f[`I2CSM_F_ARB]   = evt_arb_lost; // [RQ17]
        set_f[`I2CSM_F_NOACK] = evt_no_ack; // [RQ17]
        set_f[`I2CSM_F_OVR]   = evt_data_late && st.ctl[`I2CSM_B_NOSTR]; // [RQ16]
        set_f[`I2CSM_F_PEC]   = pec_check && st.ctl[`I2CSM_B_CHECKSUM_CALC_ENABLE] &&
                                (byte_data != crc); // [RQ17]
        set_f[`I2CSM_F_TMO]   = smb && evt_timeout; // [RQ18]
        set_f[`I2CSM_F_ALERT] = smb && st.alert_q && !pins_s[0]; // [RQ18]
      end
      if (st.frame_en && !soft_reset_bit) begin
        set_f[`I2CSM_F_RXFF] = st.rxf_q && !pins_s[1]; // [RQ19]
        set_f[`I2CSM_F_TXFR] = !st.tx_frame && next_st.tx_frame; // [RQ19]
        set_f[`I2CSM_F_TXFF] = st.tx_frame && !next_st.tx_frame; // [RQ20]
      end
      // flags clear by writing zero; a set in the same cycle wins
      if (wr && hit_flags) begin
        clr_f = ~pwdata[9:0] & {{2{pstrb[1]}}, {8{pstrb[0]}}};
      end
      next_st.flags = (st.flags & ~clr_f) | set_f;

      // soft reset holds the controller side idle
      if (ctl_w[`I2CSM_B_SRST]) begin
        next_st.flags      = `I2CSM_FLAGS_RESET; // [RQ1]
        next_st.scl_oe     = 1'b0;
        next_st.tx_frame   = 1'b0;
        next_st.gc_respond = 1'b0;
        next_st.ack_next   = 1'b0;
        next_st.pec_next   = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st       <= '0;
      st.ctl   <= `I2CSM_CTL_RESET; // [RQ21]
      st.flags <= `I2CSM_FLAGS_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign pready       = st.ready;
  assign prdata       = st.rdata;
  assign pslverr      = st.slverr;
  assign alert_pin_o  = 1'b0;
  assign alert_pin_oe = st.alert_oe;
  assign scl_o        = 1'b0;
  assign scl_oe       = st.scl_oe;
  assign tx_frame     = st.tx_frame;
  assign core_enable  = st.run;
  assign start_req    = st.ctl[`I2CSM_B_START];
  assign stop_req     = st.ctl[`I2CSM_B_STOP];
  assign rx_ack       = st.rx_ack;
  assign rx_pec_byte  = st.rx_pec;
  assign pec_enable   = st.ctl[`I2CSM_B_CHECKSUM_CALC_ENABLE];
  assign smbus_mode   = st.ctl[`I2CSM_B_SMB]; // [RQ14]
  assign smbus_host   = st.ctl[`I2CSM_B_ROLE]; // [RQ13]
  assign arp_support  = st.ctl[`I2CSM_B_ADDRESS_RESOLUTION_ENABLE]; // [RQ12]
  assign gc_respond   = st.gc_respond;
  assign pec_value    = crc;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_soft_reset_bit_hold: assert property (
    clk_en && soft_reset_bit && !(wr && hit_ctl)
    |=> !core_enable && !scl_oe && (st.flags == '0)) // [RQ1]
    else $error("soft reset did not hold the controller");

  a_alert_drive: assert property (
    clk_en && st.ctl[`I2CSM_B_ALERT] && !soft_reset_bit && !alert_served && !(wr && hit_ctl)
    |=> alert_pin_oe) // [RQ2]
    else $error("alert pin not driven while alert requested");

  a_pectx_clear: assert property (
    clk_en && (evt_pec_done || evt_start) && !(wr && hit_ctl)
    |=> !st.ctl[`I2CSM_B_PECTX]) // [RQ3]
    else $error("checksum transfer bit not cleared");

  a_ack_current: assert property (
    clk_en && !st.ctl[`I2CSM_B_ACKPOS] && !(wr && hit_ctl) && st.ctl[`I2CSM_B_EN]
    |=> rx_ack == $past(st.ctl[`I2CSM_B_ACKNOWLEDGE_ENABLE])) // [RQ4] [RQ5]
    else $error("ack for current byte does not follow enable");

  a_stop_timeout: assert property (
    clk_en && st.run && smb && evt_timeout |=> stop_req && st.flags[`I2CSM_F_TMO]) // [RQ6]
    else $error("timeout did not request stop and flag");

  a_start_clear: assert property (
    clk_en && evt_start && !(wr && hit_ctl) |=> !start_req) // [RQ7]
    else $error("start request not cleared on start");

  a_disable_clear: assert property (
    clk_en && !st.ctl[`I2CSM_B_EN] && !(wr && hit_ctl)
    |=> !st.ctl[`I2CSM_B_ACKNOWLEDGE_ENABLE] && !st.ctl[`I2CSM_B_ACKPOS] && !start_req) // [RQ8]
    else $error("disabled controller kept ack or start bits");

  a_no_stretch: assert property (
    clk_en && st.ctl[`I2CSM_B_NOSTR] |=> !scl_oe) // [RQ9]
    else $error("clock stretched while stretching disabled");

  a_gc_ignore: assert property (
    gc_respond |-> $past(st.ctl[`I2CSM_B_GENERAL_CALL_ENABLE]) && $past(byte_data[7:1]) == 7'h00) // [RQ10]
    else $error("general call answered while disabled");

  a_ovr_flag: assert property (
    clk_en && st.run && evt_data_late && st.ctl[`I2CSM_B_NOSTR]
    |=> st.flags[`I2CSM_F_OVR] [*2] or !clk_en || soft_reset_bit) // [RQ16]
    else $error("overrun not flagged without stretching");

  a_txf_edges: assert property (
    clk_en && st.frame_en && !soft_reset_bit && $fell(tx_frame) |-> st.flags[`I2CSM_F_TXFF]) // [RQ20]
    else $error("tx frame fall not flagged");

  a_rsvd_zero: assert property (
    pready && hit_ctl && $past(psel) |-> prdata[31:16] == 16'h0000 &&
    !prdata[14] && !prdata[2]) // [RQ23]
    else $error("reserved control bits read nonzero");

  c_start_req:  cover property (wr && hit_ctl && pwdata[`I2CSM_B_START] && pstrb[1]);
  c_timeout:    cover property (st.run && smb && evt_timeout);
  c_pec_fail:   cover property (set_f[`I2CSM_F_PEC]);
  c_rx_fall:    cover property (set_f[`I2CSM_F_RXFF]);
endmodule

/* File: test/i2csm_far_end.sv */
// far-side model: another smbus party on the alert line and a frame source
`timescale 1ns/100ps
module i2csm_far_end (
  input  wire logic alert_pin_oe,
  input  wire logic pull_alert,
  input  wire logic drop_frame,
  output logic      alert_line,
  output logic      rx_frame
);
  logic link_clk;
  logic alert_drv;
  // ---------------------------------------------------------------
  // own timebase, unrelated in phase to sys_clk
  // ---------------------------------------------------------------
  initial begin
    link_clk = 1'b0;
    alert_drv = 1'b0;
    rx_frame = 1'b1;
    #1.3;
    forever #40 link_clk = ~link_clk;
  end
  always @(posedge link_clk) begin
    alert_drv <= pull_alert;
    rx_frame <= ~drop_frame;
  end
  // open-drain line with pull-up: low while either party pulls
  assign alert_line = ~(alert_pin_oe | alert_drv);
endmodule

/* File: test/tb_i2c_smbus_control_and_flags.sv */
// self-checking bench for the control register and flag block
`timescale 1ns/100ps
`include "i2csm_defs.svh"
module tb_i2c_smbus_control_and_flags;
  logic        sys_clk;
  logic        rst_n;
  logic        clk_en;
  logic        rx_pec_byte;
  logic [7:0]  paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic [11:0] ev;
  logic [7:0]  byte_data;
  logic        slave_active;
  logic        data_wait;
  logic        master_busy;
  logic        pull_alert;
  logic        drop_frame;
  logic        alert_line;
  logic        rx_frame;
  logic        alert_pin_oe;
  logic        scl_oe;
  logic        tx_frame;
  logic        core_enable;
  logic        start_req;
  logic        stop_req;
  logic        rx_ack;
  logic        pec_enable;
  logic        smbus_mode;
  logic        smbus_host;
  logic        arp_support;
  logic        gc_respond;
  logic [7:0]  pec_value;
  int          failures;
  int          tests_run;

  i2csm_ctrl u_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .evt_start(ev[0]), .evt_stop(ev[1]),
    .evt_pec_done(ev[2]), .evt_timeout(ev[3]), .evt_bus_err(ev[4]), .evt_arb_lost(ev[5]),
    .evt_no_ack(ev[6]), .evt_data_late(ev[7]), .byte_done(ev[8]), .byte_data(byte_data),
    .pec_check(ev[9]), .addr_valid(ev[10]), .slave_active(slave_active),
    .data_wait(data_wait), .master_busy(master_busy), .alert_served(ev[11]),
    .alert_pin_i(alert_line), .rx_frame_i(rx_frame), .alert_pin_o(),
    .alert_pin_oe(alert_pin_oe), .scl_o(), .scl_oe(scl_oe), .tx_frame(tx_frame),
    .core_enable(core_enable), .start_req(start_req), .stop_req(stop_req), .rx_ack(rx_ack),
    .rx_pec_byte(rx_pec_byte), .pec_enable(pec_enable), .smbus_mode(smbus_mode),
    .smbus_host(smbus_host), .arp_support(arp_support), .gc_respond(gc_respond),
    .pec_value(pec_value));

  i2csm_far_end u_far (.alert_pin_oe(alert_pin_oe), .pull_alert(pull_alert),
    .drop_frame(drop_frame), .alert_line(alert_line), .rx_frame(rx_frame));

  always #2 sys_clk = ~sys_clk;

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    if (failures == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] r, output logic e);
    int n;
    @(posedge sys_clk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    pstrb <= s;
    psel <= 1'b1;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16) begin
      failures++;
      conclude();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
    logic [31:0] r;
    logic        e;
    apb(a, 1'b1, d, s, r, e);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(a, 1'b0, 32'h0, 4'h0, r, e);
    chk(r, exp);
  endtask

  // reads flags until bit b is set or the bound runs out, then compares
  task automatic poll_flag(input int b, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    int          n;
    n = 0;
    do begin
      apb(`I2CSM_OFF_FLAGS, 1'b0, 32'h0, 4'h0, r, e);
      n++;
    end while (r[b] !== 1'b1 && n < 40);
    chk(r, exp);
  endtask

  task automatic pulse(input int i, input int n);
    @(posedge sys_clk);
    ev[i] <= 1'b1;
    @(posedge sys_clk);
    ev[i] <= 1'b0;
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  function automatic logic [7:0] crc8(input logic [7:0] b);
    logic [7:0] c;
    c = `I2CSM_CRC_INIT ^ b;
    for (int k = 0; k < 8; k++) c = c[7] ? {c[6:0], 1'b0} ^ `I2CSM_CRC_POLY : {c[6:0], 1'b0};
    return c;
  endfunction

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic s_reset();
    logic [31:0] r;
    logic        e;
    rdc(`I2CSM_OFF_CTL, 32'h0);
    rdc(`I2CSM_OFF_FLAGS, 32'h0);
    apb(8'h20, 1'b0, 32'h0, 4'h0, r, e);
    chk(32'(e), 32'h1);
    chk(r, 32'h0);
  endtask

  task automatic s_fields();
    wr(`I2CSM_OFF_CTL, 32'hffffffff);
    rdc(`I2CSM_OFF_CTL, 32'h0000bffb);
    chk(32'(core_enable), 32'h0);
    chk(32'({start_req, stop_req, pec_enable}), 32'h7);
    chk(32'({arp_support, smbus_host, smbus_mode}), 32'h7);
    wr(`I2CSM_OFF_CTL, 32'h0, 4'h3);
    rdc(`I2CSM_OFF_CTL, 32'h0);
    chk(32'({pec_enable, arp_support}), 32'h0);
    chk(32'({smbus_host, smbus_mode}), 32'h0);
    wr(`I2CSM_OFF_CTL, 32'hffff0000, 4'hc);
    rdc(`I2CSM_OFF_CTL, 32'h0);
    wr(`I2CSM_OFF_CTL, 32'h1);
    rdc(`I2CSM_OFF_CTL, 32'h1);
    chk(32'(core_enable), 32'h1);
  endtask

  task automatic s_hw_clears();
    wr(`I2CSM_OFF_CTL, 32'h1303);
    pulse(0, 2);
    rdc(`I2CSM_OFF_CTL, 32'h0203);
    pulse(1, 2);
    rdc(`I2CSM_OFF_CTL, 32'h0003);
    pulse(3, 2);
    rdc(`I2CSM_OFF_CTL, 32'h0203);
    rdc(`I2CSM_OFF_FLAGS, 32'h20);
    wr(`I2CSM_OFF_CTL, 32'h1d02);
    rdc(`I2CSM_OFF_CTL, 32'h0002);
    wr(`I2CSM_OFF_FLAGS, 32'h0);
    rdc(`I2CSM_OFF_FLAGS, 32'h0);
  endtask

  task automatic s_ack();
    wr(`I2CSM_OFF_CTL, 32'h1401);
    rdc(`I2CSM_OFF_CTL, 32'h1401);
    chk(32'(rx_ack), 32'h1);
    chk(32'(rx_pec_byte), 32'h1);
    wr(`I2CSM_OFF_CTL, 32'h0801);
    rdc(`I2CSM_OFF_CTL, 32'h0801);
    chk(32'(rx_ack), 32'h0);
    wr(`I2CSM_OFF_CTL, 32'h0c01);
    rdc(`I2CSM_OFF_CTL, 32'h0c01);
    chk(32'(rx_ack), 32'h0);
    pulse(8, 2);
    chk(32'(rx_ack), 32'h1);
  endtask

  task automatic s_errors();
    wr(`I2CSM_OFF_CTL, 32'h1);
    pulse(7, 2);
    rdc(`I2CSM_OFF_FLAGS, 32'h0);
    @(posedge sys_clk);
    clk_en <= 1'b0;
    pulse(4, 1);
    @(posedge sys_clk);
    clk_en <= 1'b1;
    rdc(`I2CSM_OFF_FLAGS, 32'h0);
    @(posedge sys_clk);
    slave_active <= 1'b1;
    data_wait <= 1'b1;
    rdc(`I2CSM_OFF_CTL, 32'h1);
    chk(32'(scl_oe), 32'h1);
    wr(`I2CSM_OFF_CTL, 32'h00a1);
    rdc(`I2CSM_OFF_CTL, 32'h00a1);
    chk(32'(scl_oe), 32'h0);
    for (int i = 4; i < 8; i++) pulse(i, 2);
    @(posedge sys_clk);
    byte_data <= 8'ha5;
    pulse(8, 2);
    chk(32'(pec_value), 32'(crc8(8'ha5)));
    @(posedge sys_clk);
    byte_data <= 8'h00;
    pulse(9, 2);
    rdc(`I2CSM_OFF_FLAGS, 32'h1f);
    wr(`I2CSM_OFF_FLAGS, 32'h0);
    rdc(`I2CSM_OFF_FLAGS, 32'h0);
  endtask

  task automatic s_alert();
    wr(`I2CSM_OFF_CTL, 32'h1);
    @(posedge sys_clk);
    pull_alert <= 1'b1;
    poll_flag(6, 32'h0);
    @(posedge sys_clk);
    pull_alert <= 1'b0;
    poll_flag(6, 32'h0);
    wr(`I2CSM_OFF_CTL, 32'h3);
    @(posedge sys_clk);
    pull_alert <= 1'b1;
    poll_flag(6, 32'h40);
    @(posedge sys_clk);
    pull_alert <= 1'b0;
    wr(`I2CSM_OFF_CTL, 32'h2003);
    rdc(`I2CSM_OFF_CTL, 32'h2003);
    chk(32'(alert_pin_oe), 32'h1);
    pulse(11, 2);
    rdc(`I2CSM_OFF_CTL, 32'h0003);
    chk(32'(alert_pin_oe), 32'h0);
  endtask

  task automatic s_frame();
    wr(`I2CSM_OFF_FLAGS, 32'h0);
    wr(`I2CSM_OFF_FRAME, 32'h1);
    @(posedge sys_clk);
    drop_frame <= 1'b1;
    poll_flag(7, 32'h80);
    @(posedge sys_clk);
    master_busy <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    chk(32'(tx_frame), 32'h1);
    @(posedge sys_clk);
    master_busy <= 1'b0;
    poll_flag(9, 32'h380);
  endtask

  task automatic s_gc();
    wr(`I2CSM_OFF_CTL, 32'h0041);
    for (int i = 0; i < 3; i++) begin
      if (i == 2) wr(`I2CSM_OFF_CTL, 32'h1);
      @(posedge sys_clk);
      byte_data <= (i == 1) ? 8'hb4 : 8'h00;
      pulse(10, 0);
      chk(32'(gc_respond), (i == 0) ? 32'h1 : 32'h0);
    end
  endtask

  initial begin
    sys_clk = 1'b0;
    rst_n = 1'b0;
    clk_en = 1'b1;
    paddr = 8'h00;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h0;
    pstrb = 4'h0;
    ev = 12'h000;
    byte_data = 8'h00;
    slave_active = 1'b0;
    data_wait = 1'b0;
    master_busy = 1'b0;
    pull_alert = 1'b0;
    drop_frame = 1'b0;
    failures = 0;
    tests_run = 0;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    s_reset();
    s_fields();
    s_hw_clears();
    s_ack();
    s_errors();
    s_alert();
    s_frame();
    s_gc();
    conclude();
  end
endmodule
